// ===== hw/bdf_port.sv
// bdf_port: burst read path, dma request handshake and fast output of the host port
// assumes the flash path offers a 32-bit plane pair whenever plane_rd is pulsed,
// and that sector_done/ecc_error/dma_start come from logic on sys_clk
//
// Summary of operation
// - burst reads take 32 bits from both planes, hand out 16-bit words per clock.
// - bursts are read only; a write cycle never starts a burst.
// - burst clock counts only while burst enable is set.
// - invert clear samples select on rising edge; set samples on falling edge.
// - falling-edge sampling adds half a cycle; data still moves on rising edges.
// - burst clock ignored while hardware reset input is low.
// - first word two cycles after sampling edge plus latency; then one per cycle.
// - hold set keeps each word for two clock cycles.
// - active-low request output moves up to 32KB in one dma run.
// - edge mode pulses the request low for 250 to 500 ns per page.
// - level mode holds the request low until the block ends.
// - starting dma with enable set raises a request at once.
// - ecc error raises interrupt and stops; else request next sector.
// - after last sector raise interrupt and one extra request.
// - clearing enable after a whole block stops further requests.
// - fast output turns drivers on as soon as select and output enable are low in ordinary (non-burst) reads.
`timescale 1ns/1ps
module bdf_port (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    // host pins, asynchronous
    input  wire logic                       burst_clk,
    input  wire logic                       ce_n,
    input  wire logic                       oe_n,
    input  wire logic                       we_n,
    input  wire logic                       hw_reset_in_n,
    // burst and fast output control bits
    input  wire logic                       burst_read_mode,
    input  wire logic                       clock_edge_invert,
    input  wire logic [bdf_pkg::LAT_W-1:0]  burst_latency,
    input  wire logic                       burst_hold,
    input  wire logic [bdf_pkg::LEN_W-1:0]  burst_length,
    input  wire logic                       fast_output_en,
    // flash plane pair and single-read data
    input  wire logic [31:0]                plane_data,
    input  wire logic [15:0]                single_rd_data,
    output logic                            plane_rd,
    // host data bus
    output logic      [15:0]                data_out,
    output logic                            data_oe,
    // dma control bits and events
    input  wire logic                       dma_start,
    input  wire logic                       dma_en,
    input  wire logic                       dma_edge_mode,
    input  wire logic [bdf_pkg::SEC_W-1:0]  dma_sector_count,
    input  wire logic                       sector_done,
    input  wire logic                       ecc_error,
    input  wire logic                       irq_clear,
    // dma outputs
    output logic                            dma_request_n,
    output logic                            irq_n,
    output logic                            dma_ecc_stop
);
    localparam int PW = bdf_pkg::DMA_PULSE_CYC;

    bdf_pkg::bdf_state_t st_q;
    bdf_pkg::bdf_state_t st_d;

    logic [4:0] pin_s;
    logic       clk_s;
    logic       ce_n_s;
    logic       oe_n_s;
    logic       we_n_s;
    logic       rst_n_s;

    bdf_sync #(.W(5)) u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in ({burst_clk, ce_n, oe_n, we_n, hw_reset_in_n}),
        .rst_val  (5'h0f),
        .sync_out (pin_s)
    );

    assign clk_s   = pin_s[4];
    assign ce_n_s  = pin_s[3];
    assign oe_n_s  = pin_s[2];
    assign we_n_s  = pin_s[1];
    assign rst_n_s = pin_s[0];

    logic rise;
    logic fall;
    logic samp;
    logic active_rd;
    logic clk_live;

    always_comb begin
        clk_live  = burst_read_mode & rst_n_s;
        rise      = clk_live & clk_s & ~st_q.prev_clk;
        fall      = clk_live & ~clk_s & st_q.prev_clk;
        samp      = clock_edge_invert ? fall : rise;
        active_rd = rst_n_s & ~ce_n_s & ~oe_n_s & we_n_s;
    end

    always_comb begin
        st_d          = st_q;
        st_d.prev_clk = clk_s;
        st_d.plane_rd = 1'b0;

        // burst read engine
        unique case (st_q.bst)
            bdf_pkg::BDF_B_IDLE: begin
                st_d.hold_ph = 1'b0;
                if (samp && active_rd) begin
                    // pair fetched now so it is ready by the first drive edge
                    st_d.bst        = bdf_pkg::BDF_B_LAT;
                    st_d.edge_cnt   = '0;
                    st_d.words_left = burst_length;
                    st_d.pair       = plane_data;
                    st_d.plane_rd   = 1'b1;
                    st_d.upper      = 1'b0;
                    st_d.data_oe    = 1'b0;
                end else if (active_rd && !burst_read_mode) begin
                    st_d.data = single_rd_data;
                    if (fast_output_en || st_q.oe_dly == bdf_pkg::NORMAL_OE_LAST) begin
                        st_d.data_oe = 1'b1;
                    end else begin
                        st_d.oe_dly = st_q.oe_dly + 3'd1;
                    end
                end else begin
                    st_d.data_oe = 1'b0;
                    st_d.oe_dly  = '0;
                end
            end
            bdf_pkg::BDF_B_LAT: begin
                // counting rising edges after a falling sample edge adds the half cycle
                if (rise) begin
                    st_d.edge_cnt = st_q.edge_cnt + 4'd1;
                    // drive on rising edge latency+1, latchable one edge later
                    if (st_q.edge_cnt == {1'b0, burst_latency}) begin
                        st_d.bst        = bdf_pkg::BDF_B_DATA;
                        st_d.data       = st_q.pair[15:0];
                        st_d.upper      = 1'b1;
                        st_d.data_oe    = 1'b1;
                        st_d.words_left = st_q.words_left - 8'd1;
                    end
                end
            end
            bdf_pkg::BDF_B_DATA: begin
                if (rise) begin
                    if (burst_hold && !st_q.hold_ph) begin
                        st_d.hold_ph = 1'b1;
                    end else begin
                        st_d.hold_ph = 1'b0;
                        if (st_q.words_left == '0) begin
                            // length reached: no further pointer movement
                            st_d.bst     = bdf_pkg::BDF_B_END;
                            st_d.data_oe = 1'b0;
                        end else if (st_q.upper) begin
                            st_d.data       = st_q.pair[31:16];
                            st_d.upper      = 1'b0;
                            st_d.words_left = st_q.words_left - 8'd1;
                        end else begin
                            st_d.pair       = plane_data;
                            st_d.plane_rd   = 1'b1;
                            st_d.data       = plane_data[15:0];
                            st_d.upper      = 1'b1;
                            st_d.words_left = st_q.words_left - 8'd1;
                        end
                    end
                end
            end
            bdf_pkg::BDF_B_END: begin
                st_d.data_oe = 1'b0;
            end
        endcase

        // host dropping the cycle, burst off or hardware reset ends any burst
        if (st_q.bst != bdf_pkg::BDF_B_IDLE && (!active_rd || !clk_live)) begin
            st_d.bst     = bdf_pkg::BDF_B_IDLE;
            st_d.data_oe = 1'b0;
            st_d.oe_dly  = '0;
        end

        // clear first, so that an interrupt event below in the same cycle wins
        if (irq_clear) begin
            st_d.irq_n = 1'b1;
        end

        // dma request engine
        unique case (st_q.dst)
            bdf_pkg::BDF_D_IDLE: begin
                st_d.req_n = 1'b1;
                if (dma_start && dma_en) begin
                    st_d.sec_left = dma_sector_count;
                    st_d.ecc_stop = 1'b0;
                    st_d.dst      = bdf_pkg::BDF_D_GAP;
                    st_d.req_n    = 1'b0;
                    if (dma_edge_mode) begin
                        st_d.dst       = bdf_pkg::BDF_D_PULSE;
                        st_d.pulse_cnt = bdf_pkg::DMA_PULSE_LAST;
                    end else begin
                        st_d.dst = bdf_pkg::BDF_D_WAIT;
                    end
                end
            end
            bdf_pkg::BDF_D_PULSE: begin
                if (st_q.pulse_cnt == '0) begin
                    st_d.req_n = 1'b1;
                    st_d.dst   = bdf_pkg::BDF_D_WAIT;
                end else begin
                    st_d.pulse_cnt = st_q.pulse_cnt - 6'd1;
                end
            end
            bdf_pkg::BDF_D_WAIT: begin
                if (sector_done) begin
                    st_d.req_n = 1'b1;
                    if (ecc_error) begin
                        st_d.irq_n    = 1'b0;
                        st_d.ecc_stop = 1'b1;
                        st_d.dst      = bdf_pkg::BDF_D_IDLE;
                    end else if (st_q.sec_left == '0 || !dma_en) begin
                        st_d.dst = bdf_pkg::BDF_D_IDLE;
                    end else begin
                        st_d.sec_left = st_q.sec_left - 7'd1;
                        st_d.dst      = bdf_pkg::BDF_D_GAP;
                        if (st_q.sec_left == 7'd1) begin
                            st_d.irq_n = 1'b0;
                        end
                    end
                end
            end
            bdf_pkg::BDF_D_GAP: begin
                // one idle cycle so a level request shows a clean negate per block
                st_d.req_n = 1'b0;
                if (dma_edge_mode) begin
                    st_d.dst       = bdf_pkg::BDF_D_PULSE;
                    st_d.pulse_cnt = bdf_pkg::DMA_PULSE_LAST;
                end else begin
                    st_d.dst = bdf_pkg::BDF_D_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= '{bst: bdf_pkg::BDF_B_IDLE, edge_cnt: 4'h0, words_left: 8'h00,
                      hold_ph: 1'b0, upper: 1'b0, pair: bdf_pkg::PAIR_RST,
                      data: bdf_pkg::DATA_RST, data_oe: 1'b0, plane_rd: 1'b0,
                      oe_dly: 3'h0, prev_clk: 1'b0, dst: bdf_pkg::BDF_D_IDLE,
                      sec_left: 7'h00, pulse_cnt: 6'h00, req_n: 1'b1,
                      irq_n: 1'b1, ecc_stop: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign plane_rd      = st_q.plane_rd;
    assign data_out      = st_q.data;
    assign data_oe       = st_q.data_oe;
    assign dma_request_n = st_q.req_n;
    assign irq_n         = st_q.irq_n;
    assign dma_ecc_stop  = st_q.ecc_stop;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_first_drive;
        st_q.bst == bdf_pkg::BDF_B_LAT && rise && active_rd && clk_live
            && st_q.edge_cnt == {1'b0, burst_latency};
    endsequence

    sequence s_sector_ok;
        st_q.dst == bdf_pkg::BDF_D_WAIT && sector_done && !ecc_error && dma_en
            && st_q.sec_left != '0;
    endsequence

    property p_burst_needs_en;
        !burst_read_mode |=> st_q.bst == bdf_pkg::BDF_B_IDLE;
    endproperty
    a_burst_needs_en: assert property (p_burst_needs_en) else $error("burst ran while off");

    property p_hw_reset_quiet;
        !rst_n_s |=> !data_oe;
    endproperty
    a_hw_reset_quiet: assert property (p_hw_reset_quiet) else $error("drive in hw reset");

    property p_no_write_burst;
        st_q.bst == bdf_pkg::BDF_B_IDLE && !we_n_s |=> st_q.bst == bdf_pkg::BDF_B_IDLE;
    endproperty
    a_no_write_burst: assert property (p_no_write_burst) else $error("burst on write");

    property p_first_word;
        s_first_drive |=> data_oe && data_out == $past(st_q.pair[15:0]);
    endproperty
    a_first_word: assert property (p_first_word) else $error("first word wrong");

    property p_hold_word;
        st_q.bst == bdf_pkg::BDF_B_DATA && burst_hold && !st_q.hold_ph && rise
            && active_rd && clk_live |=> $stable(data_out) && data_oe;
    endproperty
    a_hold_word: assert property (p_hold_word) else $error("held word moved");

    property p_dma_start;
        st_q.dst == bdf_pkg::BDF_D_IDLE && dma_start && dma_en |=> !dma_request_n;
    endproperty
    a_dma_start: assert property (p_dma_start) else $error("no request on start");

    property p_edge_pulse;
        $fell(dma_request_n) && st_q.dst == bdf_pkg::BDF_D_PULSE |-> ##PW $rose(dma_request_n);
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("pulse width wrong");

    property p_ecc_stop;
        st_q.dst == bdf_pkg::BDF_D_WAIT && sector_done && ecc_error
            |=> !irq_n && st_q.dst == bdf_pkg::BDF_D_IDLE ##1 dma_request_n;
    endproperty
    a_ecc_stop: assert property (p_ecc_stop) else $error("ecc did not stop");

    property p_next_request;
        s_sector_ok |=> dma_request_n ##1 !dma_request_n;
    endproperty
    a_next_request: assert property (p_next_request) else $error("no next request");

    property p_done_irq;
        s_sector_ok ##0 st_q.sec_left == 7'h01 |=> !irq_n ##1 !dma_request_n;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("no completion interrupt");

    property p_abort;
        st_q.dst == bdf_pkg::BDF_D_WAIT && sector_done && !dma_en
            |=> dma_request_n [*3];
    endproperty
    a_abort: assert property (p_abort) else $error("request after abort");

    property p_fast_out;
        st_q.bst == bdf_pkg::BDF_B_IDLE && active_rd && !burst_read_mode && fast_output_en
            |=> data_oe;
    endproperty
    a_fast_out: assert property (p_fast_out) else $error("fast output late");

endmodule // bdf_port

// ===== include/bdf_pkg.sv
// bdf_pkg: constants, states and the state record of the burst/dma/fast-read port
// assumes a 100 MHz sys_clk; host pins reach the block through bdf_sync
package bdf_pkg;

    // system clock period, used to turn times into cycle counts
    localparam int unsigned SYS_CLK_NS     = 10;

    // request pulse in edge mode: inside the 250..500 ns window
    localparam int unsigned DMA_PULSE_NS   = 300;
    localparam int unsigned DMA_PULSE_CYC  = (DMA_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [5:0]  DMA_PULSE_LAST = 6'(DMA_PULSE_CYC - 1);

    // output driver turn-on delay for ordinary (not fast) reads
    localparam int unsigned NORMAL_OE_NS   = 40;
    localparam int unsigned NORMAL_OE_CYC  = (NORMAL_OE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [2:0]  NORMAL_OE_LAST = 3'(NORMAL_OE_CYC - 1);

    // field widths
    localparam int unsigned LAT_W  = 3;
    localparam int unsigned LEN_W  = 8;
    localparam int unsigned SEC_W  = 7;

    // reset values
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [31:0] PAIR_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        BDF_B_IDLE = 2'b00,
        BDF_B_LAT  = 2'b01,
        BDF_B_DATA = 2'b10,
        BDF_B_END  = 2'b11
    } bdf_bst_t;

    typedef enum logic [1:0] {
        BDF_D_IDLE  = 2'b00,
        BDF_D_PULSE = 2'b01,
        BDF_D_WAIT  = 2'b10,
        BDF_D_GAP   = 2'b11
    } bdf_dst_t;

    typedef struct packed {
        bdf_bst_t         bst;
        logic [3:0]       edge_cnt;
        logic [LEN_W-1:0] words_left;
        logic             hold_ph;
        logic             upper;
        logic [31:0]      pair;
        logic [15:0]      data;
        logic             data_oe;
        logic             plane_rd;
        logic [2:0]       oe_dly;
        logic             prev_clk;
        bdf_dst_t         dst;
        logic [SEC_W-1:0] sec_left;
        logic [5:0]       pulse_cnt;
        logic             req_n;
        logic             irq_n;
        logic             ecc_stop;
    } bdf_state_t;

endpackage

// ===== hw/bdf_sync.sv
// bdf_sync: two-stage synchroniser for a group of asynchronous pins
// assumes the inputs are static long enough to be sampled by sys_clk
`timescale 1ns/1ps
module bdf_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // pins in, synchronised copy out
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bdf_sync_t;

    bdf_sync_t st_q;
    bdf_sync_t st_d;

    always_comb begin
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    // rst_val is a tie-off constant at every instance
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= '{s1: rst_val, s2: rst_val};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;
endmodule // bdf_sync

// ===== test/bdf_host_model.sv
// bdf_host_model: host side of the burst link, runs one framed read or write per go
// assumes go rises only while the model is idle; done stays high until the next go
`timescale 1ns/1ps
module bdf_host_model (
    // frame request
    input  wire logic       go,
    input  wire logic       rd,
    input  wire logic [2:0] lat,
    input  wire logic       hld,
    input  wire logic [7:0] len,
    // host pins
    output logic            burst_clk,
    output logic            ce_n,
    output logic            oe_n,
    output logic            we_n,
    output logic            done
);
    initial begin
        burst_clk = 1'b0;
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        done = 1'b0;
    end

    // the clock stands still at 0 between frames, as a halted host clock would
    always @(posedge go) begin
        int n;
        done = 1'b0;
        n = lat + 5 + len * (hld ? 2 : 1);
        ce_n = 1'b0;
        oe_n = !rd;
        we_n = rd;
        #62.5;
        // more edges than the words need: surplus toggling must not yield words
        repeat (n) begin
            burst_clk = 1'b1;
            #62.5;
            burst_clk = 1'b0;
            #62.5;
        end
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        #200;
        done = 1'b1;
    end
endmodule // bdf_host_model

// ===== test/test_bdf_port.sv
// test_bdf_port: self-checking bench of the burst, dma and fast output port
// assumes bdf_pkg, bdf_port and bdf_host_model are compiled beforehand
`timescale 1ns/1ps
module test_bdf_port;
    logic                      sys_clk = 1'b0;
    logic                      sys_rst = 1'b1;
    logic                      hw_reset_in_n = 1'b1;
    logic                      burst_read_mode = 1'b0;
    logic                      clock_edge_invert = 1'b0;
    logic [bdf_pkg::LAT_W-1:0] burst_latency = 3'h0;
    logic                      burst_hold = 1'b0;
    logic [bdf_pkg::LEN_W-1:0] burst_length = 8'h01;
    logic                      fast_output_en = 1'b0;
    logic [15:0]               single_rd_data = 16'h0000;
    logic                      dma_start = 1'b0;
    logic                      dma_en = 1'b0;
    logic                      dma_edge_mode = 1'b0;
    logic [bdf_pkg::SEC_W-1:0] dma_sector_count = 7'h00;
    logic                      sector_done = 1'b0;
    logic                      ecc_error = 1'b0;
    logic                      irq_clear = 1'b0;
    logic                      go = 1'b0;
    logic                      rd = 1'b1;
    logic                      bmon = 1'b0;
    logic                      prev_oe = 1'b0;
    logic [15:0]               prev_d = 16'h0000;
    logic [15:0]               base = 16'h0000;
    logic [15:0]               pidx = 16'h0000;
    logic [31:0]               plane_data;
    logic                      burst_clk, ce_n, oe_n, we_n, done;
    logic                      plane_rd, data_oe, dma_request_n, irq_n, dma_ecc_stop;
    logic [15:0]               data_out;
    logic [15:0]               exp_q[$];
    int                        run = 0;
    int                        miscompares = 0;
    int                        num_checks = 0;
    int                        i;

    always #5 sys_clk = ~sys_clk;
    // each pair holds two consecutive words, so every word differs from its neighbour
    assign plane_data = {base + 16'(2 * pidx) + 16'h0001, base + 16'(2 * pidx)};
    always @(posedge sys_clk) if (plane_rd === 1'b1) pidx <= pidx + 16'h0001;

    bdf_host_model host (.go(go), .rd(rd), .lat(burst_latency), .hld(burst_hold),
        .len(burst_length), .burst_clk(burst_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .done(done));
    bdf_port dut (.sys_clk, .sys_rst, .burst_clk, .ce_n, .oe_n, .we_n, .hw_reset_in_n,
        .burst_read_mode, .clock_edge_invert, .burst_latency, .burst_hold, .burst_length,
        .fast_output_en, .plane_data, .single_rd_data, .plane_rd, .data_out, .data_oe,
        .dma_start, .dma_en, .dma_edge_mode, .dma_sector_count, .sector_done, .ecc_error,
        .irq_clear, .dma_request_n, .irq_n, .dma_ecc_stop);

    task automatic chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // words are told apart by a change of value, which the distinct pairs guarantee
    always @(negedge sys_clk) begin
        if (bmon && data_oe === 1'b1 && (prev_oe !== 1'b1 || data_out !== prev_d)) begin
            if (prev_oe === 1'b1) chk(burst_hold ? run inside {[23:27]} : run inside {[11:14]}, "word span");
            chk(exp_q.size() != 0 && exp_q[0] === data_out, "burst word");
            if (exp_q.size() != 0) void'(exp_q.pop_front());
            run = 0;
        end
        if (burst_read_mode === 1'b0 && data_oe === 1'b1 && data_out !== single_rd_data) chk(1'b0, "single read data");
        run++;
        prev_oe = data_oe;
        prev_d = data_out;
    end

    // kind 0 burst, 1 write, 2 under hardware reset, 3 ordinary read
    task automatic burst(input int kind, input int lat, input logic inv, input logic hld,
                         input int len, input logic fast);
        int          k;
        logic [15:0] p0;
        repeat (2) @(negedge sys_clk);
        burst_read_mode = (kind != 3);
        clock_edge_invert = inv;
        burst_latency = lat[2:0];
        burst_hold = hld;
        burst_length = len[7:0];
        hw_reset_in_n = (kind != 2);
        rd = (kind != 1);
        fast_output_en = fast;
        single_rd_data = 16'($urandom);
        p0 = pidx;
        bmon = (kind == 0);
        if (kind == 0) for (k = 0; k < len; k++) exp_q.push_back(base + 16'(2 * p0) + 16'(k));
        repeat (4) @(negedge sys_clk);
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        for (k = 1; k < 3000 && data_oe !== 1'b1 && done !== 1'b1; k++) @(negedge sys_clk);
        if (kind == 0) chk(k * 10 >= 125 * lat + 150 && k * 10 <= 125 * lat + 300, "first word");
        if (kind == 3) chk(fast ? k <= 4 : (k >= 5 && k <= 9), "driver turn-on");
        if (kind == 1 || kind == 2) chk(done === 1'b1, "driven without read");
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge sys_clk);
        chk(exp_q.size() == 0, "word count");
        chk(pidx === p0 + 16'((kind == 0) ? (len + 1) / 2 : 0), "plane fetches");
        bmon = 1'b0;
        hw_reset_in_n = 1'b1;
    endtask

    task automatic dma_run(input logic edg, input int n, input int err, input int abt);
        int   s;
        int   k;
        logic ok;
        dma_edge_mode = edg;
        dma_sector_count = n[6:0];
        dma_en = 1'b1;
        dma_start = 1'b1;
        @(negedge sys_clk);
        dma_start = 1'b0;
        for (s = 0; s <= n; s++) begin
            for (k = 0; k < 10 && dma_request_n !== 1'b0; k++) @(negedge sys_clk);
            chk(k < 4, "request late");
            chk(irq_n === ((s == n) ? 1'b0 : 1'b1), "completion interrupt");
            if (edg) begin
                for (k = 0; k < 80 && dma_request_n === 1'b0; k++) @(negedge sys_clk);
                chk(k >= 25 && k <= 50, "pulse width");
            end else begin
                repeat (40) @(negedge sys_clk);
                chk(dma_request_n === 1'b0, "level dropped");
            end
            ecc_error = (s == err);
            dma_en = (s != abt);
            sector_done = 1'b1;
            @(negedge sys_clk);
            sector_done = 1'b0;
            ecc_error = 1'b0;
            if (s == err || s == abt || s == n) break;
        end
        ok = 1'b1;
        repeat (60) begin
            @(negedge sys_clk);
            if (dma_request_n !== 1'b1) ok = 1'b0;
        end
        chk(ok, "request after stop");
        chk(irq_n === ((s == abt) ? 1'b1 : 1'b0), "stop interrupt");
        chk(dma_ecc_stop === (s == err), "ecc stop flag");
        if (s == err && burst_read_mode === 1'b1) begin
            repeat (7) burst(1, 0, 1'b0, 1'b0, 1, 1'b0);
            burst_read_mode = 1'b0;
            chk(irq_n === 1'b0, "interrupt held");
        end
        irq_clear = 1'b1;
        @(negedge sys_clk);
        irq_clear = 1'b0;
        @(negedge sys_clk);
        chk(irq_n === 1'b1, "interrupt clear");
    endtask

    // a hang here costs a mismatch; the tests need at most about 75 us
    initial begin
        #500000;
        miscompares++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h0000_0962));
        base = 16'($urandom);
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(data_oe === 1'b0 && dma_request_n === 1'b1 && irq_n === 1'b1 && dma_ecc_stop === 1'b0, "reset");
        for (i = 0; i < 6; i++) burst(0, (i == 0) ? 7 : $urandom % 8, i[0], i[1], (i == 2) ? 1 : 2 + $urandom % 15, 1'b0);
        burst(1, 0, 1'b0, 1'b0, 4, 1'b0);
        burst(2, 0, 1'b0, 1'b0, 4, 1'b0);
        burst(3, 0, 1'b0, 1'b0, 4, 1'b0);
        burst(3, 0, 1'b0, 1'b0, 4, 1'b1);
        dma_run(1'b1, 3, -1, -1);
        dma_run(1'b0, 2, -1, -1);
        dma_run(1'b1, 64, -1, -1);
        burst_read_mode = 1'b1;
        dma_run(1'b1, 4, 1, -1);
        dma_run(1'b0, 4, -1, 2);
        wrap_up();
    end
endmodule // test_bdf_port
